// ---- hw/sslu_defs.svh ----
// Constants for the stack and segment limit unit
`ifndef SSLU_DEFS_SVH
`define SSLU_DEFS_SVH
`define SSLU_WORD_BYTES      32'h0000_0004
`define SSLU_HALF_BYTES      32'h0000_0002
`define SSLU_LIMIT_64K       32'h0000_FFFF
`define SSLU_OFFSET_16_TOP   32'h0000_FFFF
`define SSLU_TOP_ALIGNED     32'hFFFF_FFFC
`define SSLU_BASE_LOW_BITS   24
`define SSLU_LIMIT_LOW_BITS  16
`define SSLU_PAGE_SHIFT      12
`define SSLU_A20_BIT         20
`define SSLU_REAL_ADDR_MASK  32'h001F_FFFF
`endif

// ---- hw/sslu_pkg.sv ----
// Types for the stack and segment limit unit
package sslu_pkg;
  typedef enum logic [3:0] {
    SSLU_OP_NONE   = 4'h0,
    SSLU_OP_PUSH_SEL = 4'h1,
    SSLU_OP_POP_SEL  = 4'h2,
    SSLU_OP_PUSH_ERR = 4'h3,
    SSLU_OP_FAR_CALL = 4'h4,
    SSLU_OP_GATE_SAVE = 4'h5,
    SSLU_OP_GATE_RET  = 4'h6,
    SSLU_OP_PUSH     = 4'h7,
    SSLU_OP_POP      = 4'h8,
    SSLU_OP_ACCESS   = 4'h9
  } sslu_op_e;

  typedef enum logic [2:0] {
    SSLU_ST_RUN      = 3'b001,
    SSLU_ST_FAULT    = 3'b010,
    SSLU_ST_SHUTDOWN = 3'b100
  } sslu_state_e;

  typedef struct packed {
    logic [15:0] rsvd_word;
    logic [31:0] base;
    logic [19:0] limit;
    logic        gran;
    logic        def_big;
  } sslu_desc_s;

  typedef struct packed {
    logic [31:0] base;
    logic [31:0] limit;
    logic        wide;
  } sslu_seg_s;

  typedef struct packed {
    logic        stack_fault;
    logic        general_protection_fault;
    logic        branch_fault;
  } sslu_fault_s;
endpackage : sslu_pkg

// ---- hw/sslu_desc_decode.sv ----
// Segment descriptor decoder: base, limit and size
`timescale 1ns/1ps
`include "sslu_defs.svh"
module sslu_desc_decode
  import sslu_pkg::*;
(
  input  wire sslu_desc_s desc,     // Raw descriptor fields
  input  wire logic       is_stack, // Descriptor is for stack segment
  output sslu_seg_s       seg       // Decoded segment
);
  wire        legacy   = (desc.rsvd_word == 16'h0000);
  wire [31:0] base_eff = legacy ? {8'h00, desc.base[`SSLU_BASE_LOW_BITS-1:0]} : desc.base; // R9
  wire [19:0] lim_raw  = legacy ? {4'h0, desc.limit[`SSLU_LIMIT_LOW_BITS-1:0]} : desc.limit; // R10
  wire [31:0] lim_byte = {12'h000, lim_raw}; // R11
  wire [31:0] lim_page = {lim_raw, 12'hFFF};
  wire [31:0] lim_gran = desc.gran ? lim_page : lim_byte;
  wire        wide     = desc.def_big; // R8 R13
  // Small stack or data segment capped at 64K
  wire [31:0] lim_cap  = (!wide && lim_gran > `SSLU_LIMIT_64K) ? `SSLU_LIMIT_64K : lim_gran; // R12 R14
  assign seg.base  = base_eff;
  assign seg.limit = (is_stack || !wide) ? lim_cap : lim_gran;
  assign seg.wide  = wide;
endmodule : sslu_desc_decode

// ---- hw/sslu_core.sv ----
// Stack and segment limit unit top level
//
// Summary of operation
// R1 - Selector push on wide stack stores four bytes, upper zero, pointer minus four.
// R2 - Selector pop on wide stack reads four bytes, keeps low half.
// R3 - Four-byte selector pop faults if pointer plus three exceeds limit.
// R4 - Error codes pushed as 32 bits, upper half zero, pointer minus four.
// R5 - Far call branch checks resolve before any return pushes.
// R6 - Through 16-bit gate only low half of wide pointer saved.
// R7 - Return through 16-bit gate loads low half and zeroes upper half.
// R8 - Default-size flag sizes code/data, big flag sizes stack.
// R9 - Clear reserved word gives 24-bit base.
// R10 - Clear reserved word gives upper four limit bits zero.
// R11 - Clear granularity flag means byte-unit limit.
// R12 - Clear big flag data segment limited to 64 Kbytes.
// R13 - Clear default flag code segment uses 16-bit address and operand.
// R14 - Clear stack size flag uses narrow pointer, limit capped 64 Kbytes.
// R15 - 16-bit and 32-bit gate and task descriptors accepted together.
// R16 - Real mode offset crossing via code/data segment raises protection fault.
// R17 - Real mode offset crossing via stack segment raises stack fault.
// R18 - Aligned pop at top aligned item wraps pointer to zero, no fault.
// R19 - Real mode wraps at 1 MByte only while bit-20 mask asserted.
// R20 - Push on wide stack wrapping below address zero enters shutdown.
// R21 - Faulting push or pop leaves stack pointer unchanged.
`timescale 1ns/1ps
`include "sslu_defs.svh"
module sslu_core
  import sslu_pkg::*;
(
  input  wire  logic        clock,              // Core clock 10 MHz
  input  wire  logic        resetn,             // Synchronous reset, active low
  input  wire  logic        op_valid,           // Operation request, one cycle
  input  wire  sslu_op_e    op,                 // Operation code
  input  wire  logic [31:0] op_data,            // Value to push or popped value
  input  wire  logic [31:0] op_offset,          // Access offset
  input  wire  logic [2:0]  op_size,            // Access size in bytes minus one
  input  wire  logic        via_stack_seg,      // Access uses stack segment
  input  wire  logic        gate_16,            // Gate is 16-bit kind
  input  wire  logic        target_ok,          // Far call target passes checks
  input  wire  logic        real_mode,          // Real-address mode
  input  wire  logic        addr_bit20_mask_in, // Bit-20 mask pin
  input  wire  logic        sp_load,            // Load stack pointer
  input  wire  logic [31:0] sp_load_value,      // Stack pointer load value
  input  wire  sslu_desc_s  stack_desc,         // Stack segment descriptor
  input  wire  logic [31:0] seg_base_real,      // Real-mode segment base
  output logic [31:0] wide_stack_pointer,       // Current stack pointer
  output logic [15:0] narrow_stack_pointer,     // Low half of pointer
  output logic        mem_write,                // Memory write strobe
  output logic [31:0] mem_addr,                 // Memory address
  output logic [31:0] mem_wdata,                // Memory write data
  output logic [3:0]  mem_bytes,                // Bytes written minus nothing
  output logic [15:0] selector_out,             // Popped selector
  output logic        done,                     // Operation finished
  output sslu_fault_s fault,                    // Fault report, one cycle
  output logic        stack_is_wide,            // Stack uses wide pointer
  output logic        shutdown                  // Shutdown state
);
  sslu_seg_s   stk;
  sslu_state_e state;
  sslu_state_e next_state;
  logic        a20_meta;
  logic        a20_sync;

  // Sign-free 33-bit add to catch carry
  function automatic logic [32:0] add33(input logic [31:0] a, input logic [31:0] b);
    add33 = {1'b0, a} + {1'b0, b};
  endfunction : add33

  sslu_desc_decode u_stack_desc (
    .desc     (stack_desc),
    .is_stack (1'b1),
    .seg      (stk)
  );

  always_ff @(posedge clock)
  begin
    a20_meta <= addr_bit20_mask_in;
    a20_sync <= a20_meta;
  end

  wire        run       = (state == SSLU_ST_RUN);
  wire        go        = op_valid && run;
  wire        wide_stk  = stk.wide; // R8 R14
  wire [31:0] sp        = wide_stack_pointer;
  wire [31:0] sp_eff    = wide_stk ? sp : {16'h0000, sp[15:0]}; // R14
  wire [31:0] sp_push   = sp_eff - `SSLU_WORD_BYTES;
  wire [32:0] sp_pop33  = add33(sp_eff, `SSLU_WORD_BYTES);
  wire [31:0] sp_pop    = sp_pop33[31:0];
  wire        push_op   = (op == SSLU_OP_PUSH_SEL) || (op == SSLU_OP_PUSH_ERR)
                        || (op == SSLU_OP_PUSH) || (op == SSLU_OP_GATE_SAVE)
                        || (op == SSLU_OP_FAR_CALL);
  wire        pop_op    = (op == SSLU_OP_POP_SEL) || (op == SSLU_OP_POP)
                        || (op == SSLU_OP_GATE_RET);
  // Top aligned item pops without violation
  wire        top_pop   = wide_stk && (sp == `SSLU_TOP_ALIGNED); // R18
  wire [32:0] top33     = add33(sp_eff, 32'h0000_0003);
  wire [31:0] top_item  = top33[31:0];
  wire        pop_over  = !top_pop && (top_item > stk.limit || sp_pop33[32]); // R3
  wire        push_under = wide_stk ? (sp_eff < `SSLU_WORD_BYTES)
                                    : (sp_eff[15:0] < 16'h0004);
  wire        push_over  = (sp_push > stk.limit) && !push_under;
  // Wide stack push wrapping below address zero
  wire        push_wrap  = wide_stk && push_under; // R20
  wire        call_bad   = (op == SSLU_OP_FAR_CALL) && !target_ok; // R5

  // Real-mode offset crossing check
  wire [32:0] acc_end33  = add33(op_offset, {29'h0, op_size});
  wire        cross16    = real_mode && (acc_end33 > {1'b0, `SSLU_OFFSET_16_TOP});
  wire        acc_op     = (op == SSLU_OP_ACCESS);
  wire        acc_gp     = acc_op && cross16 && !via_stack_seg; // R16
  wire        acc_ss     = acc_op && cross16 && via_stack_seg;  // R17
  wire [32:0] lin33      = add33(seg_base_real, op_offset);
  wire [31:0] lin_real   = lin33[31:0] & `SSLU_REAL_ADDR_MASK;
  wire [31:0] lin_a20    = a20_sync ? (lin_real & ~(32'h1 << `SSLU_A20_BIT)) : lin_real; // R19
  wire [31:0] lin_addr   = real_mode ? lin_a20 : lin33[31:0];

  wire        ss_fault   = go && ((pop_op && pop_over) || (push_op && push_over && !call_bad)
                                  || acc_ss);
  wire        gp_fault   = go && acc_gp;
  wire        br_fault   = go && call_bad;
  wire        any_fault  = ss_fault || gp_fault || br_fault;
  wire        wrap_stop  = go && push_op && push_wrap && !call_bad;

  // Data formed for the push
  wire [31:0] push_data  = (op == SSLU_OP_PUSH_SEL) ? {16'h0000, op_data[15:0]} // R1
                         : (op == SSLU_OP_PUSH_ERR) ? {16'h0000, op_data[15:0]} // R4
                         : (op == SSLU_OP_GATE_SAVE && gate_16)
                           ? {16'h0000, sp[15:0]} // R6
                         : (op == SSLU_OP_GATE_SAVE) ? sp : op_data;
  // Pointer after a good operation
  wire [31:0] sp_after_pop = top_pop ? 32'h0000_0000 : sp_pop; // R18
  wire [31:0] sp_new_pop   = wide_stk ? sp_after_pop : {sp[31:16], sp_pop[15:0]};
  wire [31:0] sp_new_push  = wide_stk ? sp_push : {sp[31:16], sp_push[15:0]};
  wire [31:0] sp_gate_ret  = gate_16 ? {16'h0000, op_data[15:0]} : op_data; // R7 R15
  wire [31:0] next_sp      = sp_load ? sp_load_value
                           : (!go || any_fault || wrap_stop) ? sp // R21
                           : (op == SSLU_OP_GATE_RET) ? sp_gate_ret
                           : pop_op ? sp_new_pop
                           : push_op ? sp_new_push : sp;
  wire        do_write     = go && push_op && !any_fault && !wrap_stop; // R5
  wire [31:0] wr_addr      = stk.base + sp_push;
  wire [31:0] next_addr    = do_write ? wr_addr
                           : (go && acc_op) ? lin_addr
                           : (go && pop_op) ? stk.base + sp_eff : mem_addr;

  always_comb
  begin
    case (state)
      SSLU_ST_RUN:      next_state = wrap_stop ? SSLU_ST_SHUTDOWN // R20
                                   : any_fault ? SSLU_ST_FAULT : SSLU_ST_RUN;
      SSLU_ST_FAULT:    next_state = SSLU_ST_RUN;
      SSLU_ST_SHUTDOWN: next_state = SSLU_ST_SHUTDOWN;
      default:          next_state = SSLU_ST_RUN;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      state              <= SSLU_ST_RUN;
      wide_stack_pointer <= 32'h0000_0000;
      mem_write          <= 1'b0;
      mem_addr           <= 32'h0000_0000;
      mem_wdata          <= 32'h0000_0000;
      mem_bytes          <= 4'h0;
      selector_out       <= 16'h0000;
      done               <= 1'b0;
      fault              <= '0;
    end
    else
    begin
      state              <= next_state;
      wide_stack_pointer <= next_sp;
      mem_write          <= do_write;
      mem_addr           <= next_addr;
      mem_wdata          <= do_write ? push_data : mem_wdata;
      mem_bytes          <= do_write ? 4'h4 : 4'h0; // R1 R4
      if (go && op == SSLU_OP_POP_SEL && !pop_over)
        selector_out     <= op_data[15:0]; // R2
      done               <= go && !any_fault && !wrap_stop;
      fault              <= '{stack_fault: ss_fault, general_protection_fault: gp_fault,
                              branch_fault: br_fault};
    end
  end

  assign narrow_stack_pointer = wide_stack_pointer[15:0];
  assign stack_is_wide        = wide_stk;
  assign shutdown             = (state == SSLU_ST_SHUTDOWN);
endmodule : sslu_core

// ---- verif/sslu_mem_model.sv ----
// Memory model behind the unit's write port
`timescale 1ns/1ps
module sslu_mem_model
(
  input  wire logic        clock,     // Core clock
  input  wire logic        mem_write, // Write strobe
  input  wire logic [31:0] mem_addr,  // Write address
  input  wire logic [31:0] mem_wdata, // Write data
  input  wire logic [31:0] rd_addr,   // Read address
  output logic      [31:0] rd_data,   // Read data
  output int               wr_cnt     // Writes seen
);
  logic [31:0] mem [logic [31:0]];
  initial wr_cnt = 0;
  always @(posedge clock)
  begin
    if (mem_write)
    begin
      mem[mem_addr] = mem_wdata;
      wr_cnt++;
    end
    // Unwritten words read as the inverted address
    rd_data <= mem.exists(rd_addr) ? mem[rd_addr] : ~rd_addr;
  end
endmodule : sslu_mem_model

// ---- verif/sslu_core_properties.sv ----
// Port assertions for the stack and segment limit unit
`timescale 1ns/1ps
module sslu_core_properties
  import sslu_pkg::*;
(
  input wire logic clock, resetn, op_valid, gate_16, target_ok, real_mode, sp_load,
  input wire logic via_stack_seg, mem_write, done, stack_is_wide, shutdown,
  input wire sslu_op_e op,
  input wire logic [31:0] op_data, op_offset, wide_stack_pointer, mem_wdata,
  input wire logic [2:0] op_size,
  input wire logic [3:0] mem_bytes,
  input wire logic [15:0] selector_out,
  input wire sslu_desc_s stack_desc,
  input wire sslu_fault_s fault
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  sequence s_take(sslu_op_e o);
    op_valid && op == o && !sp_load && fault == 3'b000 && !shutdown;
  endsequence
  sel_push_zero_a: assert property (s_take(SSLU_OP_PUSH_SEL) ##0 stack_is_wide ##1 mem_write
    |-> mem_wdata == ($past(op_data) & 32'h0000_FFFF) && mem_bytes == 4'h4)
    else $error("selector push not zero filled");
  err_push_zero_a: assert property (s_take(SSLU_OP_PUSH_ERR) ##1 mem_write
    |-> mem_wdata[31:16] == 16'h0 && mem_bytes == 4'h4) else $error("error code push");
  sel_pop_low_a: assert property (s_take(SSLU_OP_POP_SEL) ##1 done
    |-> selector_out == 16'($past(op_data))) else $error("selector pop value");
  branch_first_a: assert property (s_take(SSLU_OP_FAR_CALL) ##0 !target_ok
    |=> fault.branch_fault && !mem_write) else $error("far call wrote before branch");
  fault_sp_hold_a: assert property (fault != 3'b000 && !$past(sp_load)
    |-> $stable(wide_stack_pointer)) else $error("fault moved pointer");
  gate_ret_zero_a: assert property (s_take(SSLU_OP_GATE_RET) ##0 (gate_16 && stack_is_wide)
    ##1 done |-> wide_stack_pointer == ($past(op_data) & 32'h0000_FFFF))
    else $error("gate return upper half");
  real_cross_a: assert property (s_take(SSLU_OP_ACCESS) ##0
    (real_mode && {1'b0, op_offset} + 33'(op_size) > 33'h0_0000_FFFF)
    |=> fault.stack_fault == $past(via_stack_seg) && fault.general_protection_fault
    == !$past(via_stack_seg)) else $error("real mode crossing fault");
  size_flag_a: assert property (stack_is_wide == stack_desc.def_big)
    else $error("stack size flag");
  shutdown_lock_a: assert property (shutdown |=> shutdown && !mem_write && !done)
    else $error("left shutdown");
  top_pop_wrap_a: assert property (s_take(SSLU_OP_POP) ##0
    (stack_is_wide && wide_stack_pointer == 32'hFFFF_FFFC)
    |=> fault == 3'b000 && wide_stack_pointer == 32'h0) else $error("top pop wrap");
endmodule : sslu_core_properties
bind sslu_core sslu_core_properties u_props (.clock, .resetn, .op_valid, .gate_16, .target_ok,
  .real_mode, .sp_load, .via_stack_seg, .mem_write, .done, .stack_is_wide, .shutdown, .op,
  .op_data, .op_offset, .wide_stack_pointer, .mem_wdata, .op_size, .mem_bytes, .selector_out,
  .stack_desc, .fault);

// ---- verif/sslu_core_tb.sv ----
// Self-checking testbench for the stack and segment limit unit
`timescale 1ns/1ps
module sslu_core_tb;
  import sslu_pkg::*;
  logic        clock = 1'b0, resetn = 1'b0, op_valid = 1'b0, via_stack_seg = 1'b0;
  logic        gate_16 = 1'b0, target_ok = 1'b1, real_mode = 1'b0, addr_bit20_mask_in = 1'b0;
  logic        sp_load = 1'b0, mem_write, done, stack_is_wide, shutdown;
  sslu_op_e    op = SSLU_OP_NONE;
  logic [31:0] op_data = 32'h0, op_offset = 32'h0, sp_load_value = 32'h0, seg_base_real = 32'h0;
  logic [31:0] wide_stack_pointer, mem_addr, mem_wdata, rd_data, rnd = 32'h4B5D, sp0;
  logic [15:0] narrow_stack_pointer, selector_out;
  logic [3:0]  mem_bytes;
  logic [2:0]  op_size = 3'h0;
  sslu_desc_s  stack_desc = '0;
  sslu_fault_s fault;
  int          error_cnt = 0, n_tests = 0, cyc = 0, wr_cnt;
  always #50 clock = ~clock;
  sslu_core DUT (.clock, .resetn, .op_valid, .op, .op_data, .op_offset, .op_size, .via_stack_seg,
    .gate_16, .target_ok, .real_mode, .addr_bit20_mask_in, .sp_load, .sp_load_value, .stack_desc,
    .seg_base_real, .wide_stack_pointer, .narrow_stack_pointer, .mem_write, .mem_addr, .mem_wdata,
    .mem_bytes, .selector_out, .done, .fault, .stack_is_wide, .shutdown);
  sslu_mem_model MEM (.clock, .mem_write, .mem_addr, .mem_wdata,
    .rd_addr(32'h1000 + wide_stack_pointer), .rd_data, .wr_cnt);
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic conclude;
    $display("Checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude
  // Idle cycle first, so a fault's dead cycle is never used
  task automatic go(input sslu_op_e o, input logic [31:0] d);
    @(negedge clock);
    op = o;
    op_data = d;
    op_valid = 1'b1;
    @(negedge clock);
    op_valid = 1'b0;
  endtask : go
  task automatic ld(input logic [31:0] v);
    @(negedge clock);
    sp_load = 1'b1;
    sp_load_value = v;
    @(negedge clock);
    sp_load = 1'b0;
  endtask : ld
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      error_cnt++;
      conclude;
    end
  end
  initial
  begin
    repeat (6) @(negedge clock);
    resetn = 1'b1;
    stack_desc = '{16'h0, 32'hAB00_1000, 20'hFFFFF, 1'b0, 1'b1};
    for (int i = 0; i < 12; i++)
    begin
      rnd = xs(rnd);
      sp0 = {20'h0, rnd[11:2], 2'b00} + 32'h100;
      addr_bit20_mask_in = rnd[5];
      seg_base_real = rnd;
      stack_desc.def_big = rnd[20] | i[0];
      ld(sp0);
      chk("wide", {31'h0, stack_is_wide}, {31'h0, stack_desc.def_big});
      go(i[0] ? SSLU_OP_PUSH_ERR : SSLU_OP_PUSH_SEL, rnd);
      chk("push data", mem_wdata, {16'h0, rnd[15:0]});
      chk("push addr", mem_addr, 32'h1000 + sp0 - 32'h4);
      chk("push sp", wide_stack_pointer, sp0 - 32'h4);
      chk("push bytes", {28'h0, mem_bytes}, 32'h4);
      @(negedge clock);
      go(SSLU_OP_POP_SEL, rd_data | {rnd[31:16], 16'h0});
      chk("pop sel", {16'h0, selector_out}, {16'h0, rnd[15:0]});
      chk("pop sp", wide_stack_pointer, sp0);
      chk("pop done", {31'h0, done}, 32'h1);
      chk("narrow", {16'h0, narrow_stack_pointer}, {16'h0, sp0[15:0]});
    end
    stack_desc.def_big = 1'b1;
    for (int k = 0; k < 2; k++)
    begin
      ld(32'hFFFD - k);
      go(SSLU_OP_POP_SEL, 32'h0);
      chk("pop limit", {29'h0, fault}, k ? 32'h0 : 32'h4);
      chk("pop sp", wide_stack_pointer, k ? 32'h1_0000 : 32'hFFFD);
    end
    target_ok = 1'b0;
    addr_bit20_mask_in = 1'b1;
    seg_base_real = 32'h000F_FFF0;
    sp0 = wr_cnt;
    go(SSLU_OP_FAR_CALL, 32'h0);
    chk("branch", {29'h0, fault}, 32'h1);
    chk("no write", wr_cnt, sp0);
    target_ok = 1'b1;
    real_mode = 1'b1;
    op_size = 3'h1;
    for (int s = 0; s < 4; s++)
    begin
      via_stack_seg = s[0];
      op_offset = s[1] ? 32'hFFFF : 32'hFFFE;
      go(SSLU_OP_ACCESS, 32'h0);
      chk("cross", {29'h0, fault}, s[1] ? (s[0] ? 32'h4 : 32'h2) : 32'h0);
      chk("a20 addr", mem_addr, (32'h000F_FFF0 + op_offset) & 32'h000F_FFFF);
    end
    real_mode = 1'b0;
    stack_desc = '{16'h1, 32'h0, 20'hFFFFF, 1'b1, 1'b1};
    gate_16 = 1'b1;
    ld(32'h1234_5678);
    go(SSLU_OP_GATE_SAVE, 32'h0);
    chk("gate save", mem_wdata, 32'h5678);
    go(SSLU_OP_GATE_RET, 32'hDEAD_BEEF);
    chk("gate ret", wide_stack_pointer, 32'hBEEF);
    ld(32'hFFFF_FFFC);
    go(SSLU_OP_POP, 32'h0);
    chk("top pop", wide_stack_pointer | {29'h0, fault}, 32'h0);
    ld(32'h2);
    go(SSLU_OP_PUSH, 32'h0);
    chk("shutdown", {30'h0, shutdown, mem_write}, 32'h2);
    conclude;
  end
endmodule : sslu_core_tb
